// >>> src/line_sense_if.sv
// Synchronised line-sense levels passed from the input synchroniser to the timing core.
interface line_sense_if;
  logic zc_level;
  logic cd_level;
  modport src (output zc_level, output cd_level);
  modport dst (input zc_level, input cd_level);
endinterface

// >>> src/line_sync.sv
// Two-stage synchroniser for the zero-cross and carrier-detect inputs.
module line_sync (
  // Clock and reset
  input  wire logic  i_sys_clk,
  input  wire logic  i_rst_n,
  // Raw line inputs
  input  wire logic  i_zc_raw,
  input  wire logic  i_cd_raw,
  // Synchronised levels
  line_sense_if.src  o_sense
);
  logic [1:0] meta_reg;
  logic [1:0] sync_reg;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= 2'h0;
      sync_reg <= 2'h0;
    end else begin
      meta_reg <= {i_cd_raw, i_zc_raw};
      sync_reg <= meta_reg;
    end
  end

  assign o_sense.zc_level = sync_reg[0];
  assign o_sense.cd_level = sync_reg[1];

  AST_SYNC_TWO_STAGE: assert property (
    @(posedge i_sys_clk) disable iff (!i_rst_n)
    ##2 (o_sense.zc_level == $past(i_zc_raw, 2)) && (o_sense.cd_level == $past(i_cd_raw, 2)))
    else $error("Synchronised level does not follow the raw input two cycles later.");
endmodule

// >>> src/powerline_zero_cross_timing.sv
// Zero-cross, carrier, envelope, dimmer, clock-tick and user-interface timing core.
`include "zc_defs.svh"

// Overview of operation
// - Every mains crossing, rising or falling, raises exactly one zero-cross event.
// - After each event the expected edge polarity flips so the opposite edge fires next.
// - The zero-cross input reads low in the negative half cycle and high above threshold.
// - Timing allows for the rising edge lagging the crossing by 64 us and falling leading by 16 us.
// - A 120 kHz carrier runs continuously and reaches the line only while the gate is on.
// - An envelope timer times each 1 ms burst and the starts of the second and third phase bursts.
// - A tick every 25 ms (40 per second) advances timekeeping and starts a key scan.
// - A postscaled carrier period timer gives the increments that delay the dimmer trigger.
// - Five push-button inputs are read for menu navigation.
// - The display is driven over eight data lines and three control lines.
// - Light sensor readings decide when dawn and dusk occur.
// - Carrier transmission starts within 236 us of a detected crossing.
// - On each event the carrier-detect input is sampled inside the 1 ms window as the bit.
module powerline_zero_cross_timing
  import zc_pkg::*;
#(
  parameter int ENV_W         = 20,
  parameter int LIGHT_W       = 10,
  parameter int BURST_CYC     = `ZC_US_TO_CYC(`ZC_BURST_US),
  parameter int PHASE_CYC     = `ZC_US_TO_CYC(`ZC_PHASE_US),
  parameter int RX_SAMPLE_CYC = `ZC_US_TO_CYC(`ZC_RX_SAMPLE_US),
  parameter int TICK_CYC      = `ZC_TICK_CYC,
  parameter int DIM_POSTSCALE = `ZC_DIM_POSTSCALE
) (
  // Clock and reset
  input  wire logic           i_sys_clk,
  input  wire logic           i_rst_n,
  // Line side
  input  wire logic           i_zero_cross_input,
  input  wire logic           i_carrier_detect_input,
  output logic                o_line_carrier,
  output logic                o_carrier_output_gate,
  output logic                o_triac_trigger,
  // Zero-cross status
  output logic                o_zc_event,
  output logic                o_zc_rising,
  output logic                o_zc_level,
  // Transmit bit request
  input  wire logic           i_tx_valid,
  input  wire logic           i_tx_bit,
  input  wire logic           i_tx_three_phase,
  output logic                o_tx_ready,
  // Received bit
  output logic                o_rx_valid,
  output logic                o_rx_bit,
  // Dimmer control
  input  wire logic           i_dim_enable,
  input  wire logic [7:0]     i_dim_level,
  // Clock tick and keys
  input  wire zc_pkg::key_t   i_key_inputs,
  output logic                o_clock_tick,
  output logic                o_second_tick,
  output zc_pkg::key_t        o_key_state,
  output zc_pkg::key_t        o_key_press,
  // Display
  input  wire logic           i_disp_load,
  input  wire zc_pkg::disp_data_t i_disp_data,
  input  wire zc_pkg::disp_ctrl_t i_disp_ctrl,
  output zc_pkg::disp_data_t  o_display_data_lines,
  output zc_pkg::disp_ctrl_t  o_display_control_lines,
  // Light sensor
  input  wire logic           i_light_valid,
  input  wire logic [LIGHT_W-1:0] i_light_sample,
  input  wire logic [LIGHT_W-1:0] i_dusk_level,
  input  wire logic [LIGHT_W-1:0] i_dawn_level,
  output logic                o_is_dark
);
  import zc_pkg::*;

  localparam logic [16:0]      ACC_MOD   = 17'(`ZC_ACC_MOD);
  localparam logic [16:0]      ACC_STEP  = 17'(`ZC_ACC_STEP);
  localparam logic [ENV_W-1:0] FALL_LEAD = ENV_W'(`ZC_FALL_LEAD_CYC);
  localparam logic [ENV_W-1:0] BURST     = ENV_W'(BURST_CYC);
  localparam logic [ENV_W-1:0] PHASE     = ENV_W'(PHASE_CYC);
  localparam logic [ENV_W-1:0] RX_AT     = ENV_W'(RX_SAMPLE_CYC);
  localparam logic [ENV_W-1:0] TX_MAX    = ENV_W'(`ZC_TX_MAX_CYC);
  localparam logic [9:0]       TRIAC_LEN = 10'(`ZC_TRIAC_PULSE_CYC);
  localparam logic [5:0]       SEC_LAST  = 6'(`ZC_TICKS_PER_SEC - 1);

  line_sense_if sense ();

  line_sync u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_zc_raw  (i_zero_cross_input),
    .i_cd_raw  (i_carrier_detect_input),
    .o_sense   (sense)
  );

  // Zero-cross edge detection with alternating polarity.
  logic primed_reg;
  logic expect_rise_reg;
  logic zc_event;

  // The first cycle after reset only learns the synchronised level, which still reads low from reset,
  // so a line that is already high at release produces a rising event once the synchroniser fills.
  assign zc_event = primed_reg && (sense.zc_level != o_zc_level)
                    && (sense.zc_level == expect_rise_reg);

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      primed_reg      <= 1'b0;
      expect_rise_reg <= 1'b1;
      o_zc_level      <= 1'b0;
      o_zc_event      <= 1'b0;
      o_zc_rising     <= 1'b0;
    end else begin
      primed_reg  <= 1'b1;
      o_zc_level  <= sense.zc_level;
      o_zc_event  <= zc_event;
      if (!primed_reg) begin
        expect_rise_reg <= ~sense.zc_level;
      end else if (zc_event) begin
        expect_rise_reg <= ~expect_rise_reg;
        o_zc_rising     <= sense.zc_level;
      end
    end
  end

  // Carrier: a phase accumulator toggles at twice 120 kHz on average; the
  // system clock does not divide evenly, so edges jitter by one clock.
  logic [16:0] acc_reg;
  logic [16:0] acc_sum;
  logic        carrier_reg;
  logic        carrier_rise;

  assign acc_sum      = acc_reg + ACC_STEP;
  assign carrier_rise = (acc_sum >= ACC_MOD) && !carrier_reg;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_reg     <= 17'h0_0000;
      carrier_reg <= 1'b0;
    end else if (acc_sum >= ACC_MOD) begin
      acc_reg     <= acc_sum - ACC_MOD;
      carrier_reg <= ~carrier_reg;
    end else begin
      acc_reg <= acc_sum;
    end
  end

  // Transmit request holding register.
  logic pend_valid_reg;
  logic pend_bit_reg;
  logic pend_three_reg;
  logic tx_bit_reg;
  logic tx_three_reg;

  assign o_tx_ready = !pend_valid_reg;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pend_valid_reg <= 1'b0;
      pend_bit_reg   <= 1'b0;
      pend_three_reg <= 1'b0;
      tx_bit_reg     <= 1'b0;
      tx_three_reg   <= 1'b0;
    end else begin
      if (zc_event) begin
        tx_bit_reg     <= pend_valid_reg && pend_bit_reg;
        tx_three_reg   <= pend_three_reg;
        pend_valid_reg <= 1'b0;
      end
      if (i_tx_valid && o_tx_ready) begin
        pend_valid_reg <= 1'b1;
        pend_bit_reg   <= i_tx_bit;
        pend_three_reg <= i_tx_three_phase;
      end
    end
  end

  // Envelope timer, anchored at the estimated true crossing.
  env_state_e       env_state_reg;
  logic [ENV_W-1:0] env_cnt_reg;
  logic [ENV_W-1:0] env_off_reg;
  logic [ENV_W-1:0] env_end;
  logic             gate_next;

  assign env_end = env_off_reg + PHASE + PHASE + BURST;

  function automatic logic in_win(input logic [ENV_W-1:0] cnt, input logic [ENV_W-1:0] st);
    in_win = (cnt >= st) && (cnt < st + BURST);
  endfunction

  assign gate_next = (env_state_reg == ENV_RUN) && tx_bit_reg
                     && (in_win(env_cnt_reg, env_off_reg)
                         || (tx_three_reg && (in_win(env_cnt_reg, env_off_reg + PHASE)
                         || in_win(env_cnt_reg, env_off_reg + PHASE + PHASE))));

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      env_state_reg <= ENV_IDLE;
      env_cnt_reg   <= '0;
      env_off_reg   <= '0;
    end else if (zc_event) begin
      env_state_reg <= ENV_RUN;
      env_cnt_reg   <= '0;
      // A rising edge arrives after the crossing, so the burst starts at once;
      // a falling edge arrives early, so the burst waits for the crossing.
      env_off_reg   <= sense.zc_level ? '0 : FALL_LEAD;
    end else begin
      unique case (env_state_reg)
        ENV_IDLE: begin
          env_cnt_reg <= '0;
        end
        ENV_RUN: begin
          env_cnt_reg <= env_cnt_reg + ENV_W'(1);
          if (env_cnt_reg == env_end) begin
            env_state_reg <= ENV_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_carrier_output_gate <= 1'b0;
      o_line_carrier        <= 1'b0;
    end else begin
      o_carrier_output_gate <= gate_next;
      o_line_carrier        <= gate_next && carrier_reg;
    end
  end

  // Receive sampling inside the first burst window.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rx_valid <= 1'b0;
      o_rx_bit   <= 1'b0;
    end else begin
      o_rx_valid <= (env_state_reg == ENV_RUN) && (env_cnt_reg == env_off_reg + RX_AT);
      if ((env_state_reg == ENV_RUN) && (env_cnt_reg == env_off_reg + RX_AT)) begin
        o_rx_bit <= sense.cd_level;
      end
    end
  end

  // Dimmer: delay in postscaled carrier periods after each crossing.
  logic       dim_step;
  logic [7:0] dim_cnt_reg;
  logic       dim_armed_reg;
  logic [9:0] triac_cnt_reg;

  tick_divider #(.DIV(DIM_POSTSCALE)) u_dim_div (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_step    (carrier_rise),
    .o_pulse   (dim_step)
  );

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dim_cnt_reg     <= 8'h00;
      dim_armed_reg   <= 1'b0;
      triac_cnt_reg   <= 10'h000;
      o_triac_trigger <= 1'b0;
    end else begin
      o_triac_trigger <= (triac_cnt_reg != 10'h000);
      if (triac_cnt_reg != 10'h000) begin
        triac_cnt_reg <= triac_cnt_reg - 10'h001;
      end
      if (zc_event) begin
        dim_cnt_reg   <= 8'h00;
        dim_armed_reg <= i_dim_enable;
      end else if (dim_armed_reg && (dim_cnt_reg == i_dim_level)) begin
        dim_armed_reg <= 1'b0;
        triac_cnt_reg <= TRIAC_LEN;
      end else if (dim_step && (dim_cnt_reg != 8'hFF)) begin
        dim_cnt_reg <= dim_cnt_reg + 8'h01;
      end
    end
  end

  // Clock tick, timekeeping and key scan.
  logic       tick;
  logic [5:0] sec_cnt_reg;

  tick_divider #(.DIV(TICK_CYC)) u_tick_div (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_step    (1'b1),
    .o_pulse   (tick)
  );

  assign o_clock_tick = tick;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sec_cnt_reg   <= 6'h00;
      o_second_tick <= 1'b0;
    end else begin
      o_second_tick <= tick && (sec_cnt_reg == SEC_LAST);
      if (tick) begin
        sec_cnt_reg <= (sec_cnt_reg == SEC_LAST) ? 6'h00 : sec_cnt_reg + 6'h01;
      end
    end
  end

  // Keys are sampled only on the tick, which also debounces them.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_key_state <= '0;
      o_key_press <= '0;
    end else if (tick) begin
      o_key_state <= i_key_inputs;
      o_key_press <= i_key_inputs & ~o_key_state;
    end else begin
      o_key_press <= '0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_display_data_lines    <= '0;
      o_display_control_lines <= '0;
    end else if (i_disp_load) begin
      o_display_data_lines    <= i_disp_data;
      o_display_control_lines <= i_disp_ctrl;
    end
  end

  // Two thresholds give hysteresis so a flickering reading does not toggle.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_is_dark <= 1'b0;
    end else if (i_light_valid) begin
      if (i_light_sample < i_dusk_level) begin
        o_is_dark <= 1'b1;
      end else if (i_light_sample > i_dawn_level) begin
        o_is_dark <= 1'b0;
      end
    end
  end

  // Helper counters for the checks below.
  logic [ENV_W-1:0] gate_len_reg;
  logic [9:0]       per_cnt_reg;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gate_len_reg <= '0;
      per_cnt_reg  <= 10'h000;
    end else begin
      gate_len_reg <= o_carrier_output_gate ? gate_len_reg + ENV_W'(1) : '0;
      per_cnt_reg  <= carrier_rise ? 10'h001 :
                      (per_cnt_reg == 10'h000) ? 10'h000 : per_cnt_reg + 10'h001;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  AST_ZC_EVENT_ON_EDGE: assert property (
    zc_event |=> o_zc_event ##1 !o_zc_event)
    else $error("Zero-cross edge did not give exactly one event pulse.");
  AST_ZC_POLARITY_FLIP: assert property (
    o_zc_event |-> (expect_rise_reg == !o_zc_rising))
    else $error("Expected edge polarity did not flip after an event.");
  AST_ZC_LEVEL_MATCH: assert property (
    o_zc_event |-> (o_zc_rising == o_zc_level))
    else $error("Event direction disagrees with the sampled line level.");
  AST_FALL_LEAD: assert property (
    (o_zc_event && !o_zc_rising) |-> (env_off_reg == FALL_LEAD))
    else $error("Falling-edge burst offset is not the lead time.");
  AST_CARRIER_GATED: assert property (
    o_line_carrier |-> o_carrier_output_gate)
    else $error("Carrier reached the line with the gate off.");
  AST_CARRIER_PERIOD: assert property (
    $rose(carrier_reg) && $past(per_cnt_reg) > 10'h001
    |-> ($past(per_cnt_reg) inside {[10'h341:10'h342]}))
    else $error("Carrier period is not 120 kHz.");
  AST_BURST_LEN: assert property (
    $fell(o_carrier_output_gate) |-> ($past(gate_len_reg) + ENV_W'(1) == BURST))
    else $error("Carrier burst length is not the burst time.");
  AST_TX_DEADLINE: assert property (
    ($rose(o_carrier_output_gate) && env_cnt_reg < PHASE) |-> (env_cnt_reg <= TX_MAX))
    else $error("First burst started too late after the crossing.");
  AST_RX_SAMPLE: assert property (
    o_rx_valid |-> (o_rx_bit == $past(sense.cd_level)))
    else $error("Received bit is not the sampled carrier-detect level.");
  AST_DIM_FIRE: assert property (
    $rose(o_triac_trigger) |-> ($past(dim_cnt_reg, 2) == $past(i_dim_level, 2)))
    else $error("Triac fired before the dim delay elapsed.");
  AST_KEY_ON_TICK: assert property (
    $changed(o_key_state) |-> $past(tick))
    else $error("Key state changed outside a scan tick.");
  AST_DISP_LOAD: assert property (
    $past(i_disp_load) |-> (o_display_data_lines == $past(i_disp_data)))
    else $error("Display data lines did not take the loaded value.");
  AST_SECOND_TICK: assert property (
    o_second_tick |-> ($past(sec_cnt_reg) == SEC_LAST))
    else $error("Second tick not on the fortieth clock tick.");

  COV_RISE_EVENT: cover property (o_zc_event && o_zc_rising);
  COV_BURST_START: cover property ($rose(o_carrier_output_gate));
  COV_RX_ONE: cover property (o_rx_valid && o_rx_bit);
  COV_TRIAC: cover property ($rose(o_triac_trigger));
endmodule

// >>> src/tick_divider.sv
// Counts enable steps and emits a one-cycle pulse on every DIV-th step.
module tick_divider #(
  parameter int DIV = 4
) (
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  // Step in, pulse out
  input  wire logic i_step,
  output logic      o_pulse
);
  localparam int W = $clog2(DIV + 1);
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_reg;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= '0;
      o_pulse <= 1'b0;
    end else begin
      o_pulse <= i_step && (cnt_reg == LAST);
      if (i_step) begin
        cnt_reg <= (cnt_reg == LAST) ? '0 : cnt_reg + W'(1);
      end
    end
  end
endmodule

// >>> src/zc_defs.svh
// Timing constants and field widths for the power-line zero-cross timing block.
`ifndef ZC_DEFS_SVH
`define ZC_DEFS_SVH

`define ZC_CLK_MHZ        100
`define ZC_REF_OSC_KHZ    7680
`define ZC_CARRIER_KHZ    120
`define ZC_ACC_MOD        (`ZC_CLK_MHZ * 1000)
`define ZC_ACC_STEP       (2 * `ZC_CARRIER_KHZ)
`define ZC_US_TO_CYC(us)  ((us) * `ZC_CLK_MHZ)

`define ZC_RISE_LAG_US    64
`define ZC_FALL_LEAD_US   16
`define ZC_TX_MAX_US      236
`define ZC_BURST_US       1000
`define ZC_PHASE_US       2778
`define ZC_RX_SAMPLE_US   500
`define ZC_TRIAC_PULSE_US 10
`define ZC_TICK_MS        25
`define ZC_TICKS_PER_SEC  40
`define ZC_DIM_POSTSCALE  4

`define ZC_FALL_LEAD_CYC   `ZC_US_TO_CYC(`ZC_FALL_LEAD_US)
`define ZC_TX_MAX_CYC      `ZC_US_TO_CYC(`ZC_TX_MAX_US)
`define ZC_TRIAC_PULSE_CYC `ZC_US_TO_CYC(`ZC_TRIAC_PULSE_US)
`define ZC_TICK_CYC        (`ZC_TICK_MS * 1000 * `ZC_CLK_MHZ)

`define ZC_KEY_W          5
`define ZC_DISP_DATA_W    8
`define ZC_DISP_CTRL_W    3

`endif

// >>> src/zc_pkg.sv
// Types shared by the zero-cross timing modules.
`include "zc_defs.svh"
package zc_pkg;
  typedef enum logic {ENV_IDLE, ENV_RUN} env_state_e;
  typedef logic [`ZC_KEY_W-1:0]       key_t;
  typedef logic [`ZC_DISP_DATA_W-1:0] disp_data_t;
  typedef logic [`ZC_DISP_CTRL_W-1:0] disp_ctrl_t;
endpackage

// >>> verif/ac_line_model.sv
// Behavioural AC line: mains half-cycle level and carrier-detect envelope of the line.
module ac_line_model #(
  parameter int HALF_CYC = 9000
) (
  // Clock
  input  wire logic i_sys_clk,
  // Control and line inputs
  input  wire logic i_run,
  input  wire logic i_burst,
  // Detector outputs
  output logic      o_zc_raw,
  output logic      o_cd_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cnt    = 0;
  logic zc_reg = 1'b0;
  logic cd_reg = 1'b0;
  assign o_zc_raw = zc_reg;
  assign o_cd_raw = cd_reg;
  // The detector switches cleanly once per half cycle; threshold noise is not modelled.
  always @(negedge i_sys_clk) begin
    if (i_run && cnt == HALF_CYC - 1) begin
      zc_reg <= ~zc_reg;
      cnt <= 0;
    end else if (i_run) begin
      cnt <= cnt + 1;
    end
    // Our own burst is the only carrier on the line, so the envelope follows it.
    cd_reg <= i_burst;
  end
endmodule

// >>> verif/test_powerline_zero_cross_timing.sv
// Self-checking bench for the zero-cross timing block driven from a behavioural AC line.
module test_powerline_zero_cross_timing import zc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF  = 9000;
  localparam int BURST = 2000;
  localparam int PHASE = 2500;
  localparam int RXS   = 20;
  localparam int TICK  = 50;
  localparam int PSC   = 2;
  localparam int NBITS = 7;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       run = 1'b1;
  logic       zc_raw, cd_raw, line_car, gate, triac, zc_ev, zc_rise, zc_lvl;
  logic       tx_ready, rx_valid, rx_bit, ctick, stick, is_dark;
  logic       tx_valid = 1'b0, tx_bit = 1'b0, tx_three = 1'b0, dim_en = 1'b1;
  logic       disp_load = 1'b0, light_valid = 1'b0, dark_exp = 1'b0, b, t;
  logic       gate_d = 1'b0, car_d = 1'b0, triac_d = 1'b0, seen_rise = 1'b0, zc_d = 1'b0;
  logic [7:0] dim_lvl = 8'h02;
  logic [9:0] light_smp = 10'h000, dusk = 10'h12c, dawn = 10'h258;
  key_t       keys = '0, key_state, key_press, press_acc = '0;
  disp_data_t disp_data = '0, disp_d_o;
  disp_ctrl_t disp_ctrl = '0, disp_c_o;
  int         error_cnt = 0, n_checks = 0, cyc = 0, zc_age = 0, since_ev = 0, bidx = 0;
  int         glen = 0, per = 0, twid = 0, tgap = 0, ntick = 0, tsec = 0;
  int         nburst = 0, exp_bursts = 0;
  integer     seed = 32'h247d_288e;
  logic       zq[$], rq[$];

  always #5 clk = ~clk;

  ac_line_model #(.HALF_CYC(HALF)) line (.i_sys_clk(clk), .i_run(run), .i_burst(gate),
    .o_zc_raw(zc_raw), .o_cd_raw(cd_raw));

  powerline_zero_cross_timing #(.BURST_CYC(BURST), .PHASE_CYC(PHASE), .RX_SAMPLE_CYC(RXS),
    .TICK_CYC(TICK), .DIM_POSTSCALE(PSC)) DUT (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_zero_cross_input(zc_raw),
    .i_carrier_detect_input(cd_raw), .o_line_carrier(line_car), .o_carrier_output_gate(gate),
    .o_triac_trigger(triac), .o_zc_event(zc_ev), .o_zc_rising(zc_rise), .o_zc_level(zc_lvl),
    .i_tx_valid(tx_valid), .i_tx_bit(tx_bit), .i_tx_three_phase(tx_three),
    .o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_bit(rx_bit), .i_dim_enable(dim_en),
    .i_dim_level(dim_lvl), .i_key_inputs(keys), .o_clock_tick(ctick), .o_second_tick(stick),
    .o_key_state(key_state), .o_key_press(key_press), .i_disp_load(disp_load),
    .i_disp_data(disp_data), .i_disp_ctrl(disp_ctrl), .o_display_data_lines(disp_d_o),
    .o_display_control_lines(disp_c_o), .i_light_valid(light_valid),
    .i_light_sample(light_smp), .i_dusk_level(dusk), .i_dawn_level(dawn), .o_is_dark(is_dark));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic wait_ready();
    int w = 0;
    while (tx_ready !== 1'b1 && w < 20000) begin
      @(negedge clk);
      w++;
    end
    if (w == 20000) check(0, 1);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      error_cnt++;
      end_sim();
    end
  end

  // Each line edge notes the event it should cause; the monitor below takes it off.
  always @(zc_raw) if (rst_n) begin
    zq.push_back(zc_raw);
  end

  // The tick edge clears the sum, so each scan sees every press since the last one.
  always @(posedge clk) if (rst_n) press_acc <= (ctick ? '0 : press_acc) | key_press;

  always @(negedge clk) begin
    zc_age = (zc_raw !== zc_d) ? 1 : zc_age + 1;
    since_ev++;
    tgap++;
    per++;
    if (zc_ev) begin
      if (zq.size() == 0) check(1, 0);
      else begin
        check(zc_rise, zq[0]);
        check(zc_lvl, zq.pop_front());
        check(zc_age >= 3 && zc_age <= 5, 1);
      end
      since_ev = 0;
      bidx = 0;
    end
    if (gate && !gate_d) begin
      check(since_ev, (zc_rise ? 1 : 1601) + bidx * PHASE);
      check(since_ev < 23600, 1);
      bidx++;
      nburst++;
      glen = 0;
      seen_rise = 1'b0;
    end
    if (gate) glen++;
    if (!gate && gate_d) check(glen, BURST);
    if (!gate) check(line_car, 0);
    // The first carrier rise inside a burst is timed from the last rise of the previous burst, so it is not a period.
    if (gate && gate_d && line_car && !car_d) begin
      if (seen_rise) check(per >= 833 && per <= 834, 1);
      per = 0;
      seen_rise = 1'b1;
    end
    if (rx_valid) begin
      check(since_ev, RXS + 1 + (zc_rise ? 0 : 1600));
      if (rq.size() == 0) check(1, 0);
      else check(rx_bit, rq.pop_front());
    end
    if (triac && !triac_d) begin
      check(since_ev >= (dim_lvl - 1) * PSC * 833 &&
            since_ev <= (dim_lvl + 1) * PSC * 834 + 4, 1);
      twid = 0;
    end
    if (triac) twid++;
    if (!triac && triac_d) check(twid, 1000);
    if (ctick) begin
      if (ntick > 0) check(tgap, TICK);
      tgap = 0;
      ntick++;
      tsec++;
    end
    if (stick) begin
      check(tsec, 40);
      tsec = 0;
    end
    gate_d = gate;
    car_d = line_car;
    triac_d = triac;
    zc_d = zc_raw;
  end

  initial begin : key_scan
    key_t prev;
    key_t cur;
    key_t press_exp;
    prev = '0;
    cur = '0;
    press_exp = '0;
    forever begin
      @(posedge ctick);
      @(negedge clk);
      check(press_acc, press_exp);
      repeat (2) @(negedge clk);
      check(key_state, cur);
      press_exp = cur & ~prev;
      prev = cur;
      cur = key_t'($random(seed));
      keys = cur;
    end
  end

  initial begin
    dim_lvl = 8'(1 + ($unsigned($random(seed)) % 3));
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 6; i++) begin
      @(negedge clk);
      disp_load = 1'b1;
      disp_data = disp_data_t'($random(seed));
      disp_ctrl = disp_ctrl_t'($random(seed));
      @(negedge clk);
      disp_load = 1'b0;
      check(disp_d_o, disp_data);
      check(disp_c_o, disp_ctrl);
    end
    $display("test display done");
    for (int i = 0; i < 12; i++) begin
      @(negedge clk);
      light_valid = 1'b1;
      light_smp = 10'($random(seed));
      if (light_smp < dusk) dark_exp = 1'b1;
      else if (light_smp > dawn) dark_exp = 1'b0;
      @(negedge clk);
      light_valid = 1'b0;
      check(is_dark, dark_exp);
    end
    $display("test light sensor done");
    // The first two bits force three-phase ones so both edge polarities carry bursts.
    for (int k = 0; k < NBITS; k++) begin
      wait_ready();
      b = (k < 2) ? 1'b1 : 1'($random(seed));
      t = (k < 2) ? 1'b1 : 1'($random(seed));
      tx_bit = b;
      tx_three = t;
      tx_valid = 1'b1;
      rq.push_back(b);
      exp_bursts += b ? (t ? 3 : 1) : 0;
      @(negedge clk);
      tx_valid = 1'b0;
      @(negedge clk);
    end
    wait_ready();
    repeat (8800) @(negedge clk);
    run = 1'b0;
    repeat (20) @(negedge clk);
    check(nburst, exp_bursts);
    check(zq.size() + rq.size(), 0);
    $display("test line traffic done");
    end_sim();
  end
endmodule
